// ---- src/pss_defs.vh ----
`ifndef PSS_DEFS_VH
`define PSS_DEFS_VH
// Clock rate and base tick
`define PSS_CLK_MHZ        100
`define PSS_TICK_US        1000
`define PSS_TICK_CYC       (`PSS_TICK_US * `PSS_CLK_MHZ)
// Register byte offsets
`define PSS_A_CURVE        8'h00
`define PSS_A_AUX_START_F  8'h04
`define PSS_A_AUX_STOP_F   8'h08
`define PSS_A_AUX_START_D  8'h0C
`define PSS_A_AUX_STOP_D   8'h10
`define PSS_A_SLEEP_F      8'h14
`define PSS_A_WAKE_F       8'h18
`define PSS_A_SLEEP_T      8'h1C
`define PSS_A_ENC_PPR      8'h20
`define PSS_A_ENC_TYPE     8'h24
`define PSS_A_DISP_FILT    8'h28
`define PSS_A_ITIME        8'h2C
`define PSS_A_CORR_LIM     8'h30
`define PSS_A_FLT_ACT      8'h34
`define PSS_A_FLT_TIME     8'h38
`define PSS_A_SLIP_LIM     8'h3C
`define PSS_A_MFO_SEL      8'h40
`define PSS_A_DISP_SEL     8'h44
`define PSS_A_GEN_START_F  8'h48
`define PSS_A_STATUS       8'h4C
`define PSS_A_SPEED        8'h50
`define PSS_A_POS          8'h54
// Reset values
`define PSS_R_AUX_STOP_F   16'h01F4
`define PSS_R_ENC_PPR      16'h0400
`define PSS_R_DISP_FILT    16'h001E
`define PSS_R_CORR_LIM     16'h07D0
`define PSS_R_FLT_TIME     16'h000A
`define PSS_R_SLIP_LIM     16'h005A
// Ranges
`define PSS_PPR_MIN        16'h0001
`define PSS_PPR_MAX        16'h1388
// Output function codes for auxiliary motors 1..3, and the speed display select code
`define PSS_MFO_AUX1       8'h1B
`define PSS_MFO_AUX3       8'h1D
`define PSS_DISP_SPEED     8'h58
// Encoder type codes
`define PSS_ENC_AB         4'h1
`define PSS_ENC_BA         4'h2
`define PSS_ENC_PID_REV    4'h4
`define PSS_ENC_PID_FWD    4'h5
`define PSS_ENC_CMD_REV    4'h8
`define PSS_ENC_CMD_FWD    4'h9
// Status bits
`define PSS_ST_SLEEP       3
`define PSS_ST_FAULT       4
`endif

// ---- src/pss_tick.v ----
`include "pss_defs.vh"
`default_nettype none
module pss_tick #(
    parameter CYC_PER_MS = `PSS_TICK_CYC
) (
    input  wire clk,
    input  wire resetn,
    output reg  tick_ms,
    output reg  tick_10ms,
    output reg  tick_100ms
);
    localparam integer LAST_I = CYC_PER_MS - 1;
    localparam [16:0]  LAST   = LAST_I[16:0];
    reg [16:0] cyc;
    reg [3:0]  ms;
    reg [3:0]  tens;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cyc        <= 17'h00000;
            ms         <= 4'h0;
            tens       <= 4'h0;
            tick_ms    <= 1'b0;
            tick_10ms  <= 1'b0;
            tick_100ms <= 1'b0;
        end else begin
            tick_ms    <= 1'b0;
            tick_10ms  <= 1'b0;
            tick_100ms <= 1'b0;
            if (cyc == LAST) begin
                cyc     <= 17'h00000;
                tick_ms <= 1'b1;
                if (ms == 4'h9) begin
                    ms        <= 4'h0;
                    tick_10ms <= 1'b1;
                    if (tens == 4'h9) begin
                        tens       <= 4'h0;
                        tick_100ms <= 1'b1;
                    end else begin
                        tens <= tens + 4'h1;
                    end
                end else begin
                    ms <= ms + 4'h1;
                end
            end else begin
                cyc <= cyc + 17'h00001;
            end
        end
    end
endmodule
`default_nettype wire

// ---- src/pss_top.v ----
`include "pss_defs.vh"
`default_nettype none
// Overview of operation
// - Curve code: user sets, 1.5 power, square
// - Zero start frequency never starts auxiliaries
// - Auxiliary count from outputs coded 27-29
// - Auxiliaries stop first in, first out
// - Separate start and stop delays, tenths
// - Stop frequency threshold, default five hertz
// - Sleep after low command, wake above threshold
// - Frequency command still computed while asleep
// - Wake ramps from general start frequency
// - Encoder pulses 1 to 5000, default 1024
// - Type codes 0,1,2: off, A leads, B leads
// - Codes 4,5 PID feedback; 8,9 command
// - Speed display refreshed every filter period
// - Zero integral time disables integral term
// - Speed correction clamped, default 20 Hz
// - Fault action: keep running, ramp, coast
// - Slip or stall error timed into fault
// - Slip compensation limited, default 90 rpm
module pss_top #(
    parameter CYC_PER_MS = `PSS_TICK_CYC
) (
    input  wire        CLK,
    input  wire        RESETN,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [7:0]  PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    input  wire        RUN,
    input  wire [15:0] FREQ_CMD,
    input  wire [15:0] SPEED_CORR,
    input  wire [15:0] SLIP_COMP,
    input  wire        FB_SLIP_ERR,
    input  wire        FB_STALL_ERR,
    input  wire        ENC_A,
    input  wire        ENC_B,
    output reg  [3:0]  MFO_OUT,
    output reg  [1:0]  CURVE_SHAPE,
    output reg         CURVE_SET2,
    output reg         OUT_ENABLE,
    output reg         WAKE_RAMP,
    output reg  [15:0] START_FREQ,
    output reg         PID_ENABLE,
    output reg         ENC_ENABLE,
    output reg         ENC_PID_FB,
    output reg         ENC_FREQ_CMD,
    output reg  [15:0] ENC_PPR,
    output reg         INTEG_EN,
    output reg  [15:0] CORR_OUT,
    output reg  [15:0] SLIP_OUT,
    output reg         FAULT_WARN,
    output reg         STOP_RAMP,
    output reg         STOP_COAST,
    output reg  [15:0] SPEED_DISP
);
    ////////////////////////////////////////////////////////////////////////
    reg  [2:0]  curve;
    reg  [15:0] aux_start_freq;
    reg  [15:0] aux_stop_freq;
    reg  [15:0] aux_start_delay;
    reg  [15:0] aux_stop_delay;
    reg  [15:0] sleep_freq;
    reg  [15:0] wake_freq;
    reg  [15:0] sleep_time;
    reg  [15:0] encoder_pulses_per_rev;
    reg  [3:0]  encoder_type_select;
    reg  [15:0] speed_display_filter;
    reg  [15:0] speed_integral_time;
    reg  [15:0] correction_freq_limit;
    reg  [1:0]  encoder_fault_action;
    reg  [15:0] encoder_fault_time;
    reg  [15:0] slip_comp_limit;
    reg  [31:0] multi_output_select;
    reg  [7:0]  display_select;
    reg  [15:0] general_start_freq;
    reg  [2:0]  aux_on;
    reg  [1:0]  head;
    reg  [1:0]  n_on;
    reg         sleeping;
    reg         fault;
    reg  [15:0] start_tmr;
    reg  [15:0] stop_tmr;
    reg  [15:0] sleep_tmr;
    reg  [15:0] fault_tmr;
    reg  [1:0]  a_sync;
    reg  [1:0]  b_sync;
    reg         a_prev;
    reg         b_prev;
    reg  [31:0] enc_pos;
    reg  [15:0] win_cnt;
    reg  [15:0] win_ms;
    reg  [31:0] rd_data;
    reg         rd_hit;
    reg  [2:0]  n_aux;
    reg  [2:0]  slot;
    reg  [3:0]  mfo_is_aux;
    reg  [3:0]  next_mfo;
    wire        tick_ms;
    wire        tick_10ms;
    wire        tick_100ms;
    wire        wr = PSEL & PENABLE & PWRITE & PREADY;
    wire [15:0] wd = PWDATA[15:0];
    wire [15:0] ppr_in;
    wire        fault_clr;
    wire        enc_step;
    wire        enc_up;
    wire        enc_inv;
    wire        enc_on;
    wire        staging;
    wire        fb_err;

    pss_tick #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_tick (
        .clk        (CLK),
        .resetn     (RESETN),
        .tick_ms    (tick_ms),
        .tick_10ms  (tick_10ms),
        .tick_100ms (tick_100ms)
    );

    ////////////////////////////////////////////////////////////////////////
    // Resolution kept in range
    assign ppr_in = (wd < `PSS_PPR_MIN) ? `PSS_PPR_MIN :
                    (wd > `PSS_PPR_MAX) ? `PSS_PPR_MAX : wd;
    assign fault_clr = wr && (PADDR == `PSS_A_STATUS) && PWDATA[`PSS_ST_FAULT];

    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            curve                  <= 3'h0;
            aux_start_freq         <= 16'h0000;
            aux_stop_freq          <= `PSS_R_AUX_STOP_F;
            aux_start_delay        <= 16'h0000;
            aux_stop_delay         <= 16'h0000;
            sleep_freq             <= 16'h0000;
            wake_freq              <= 16'h0000;
            sleep_time             <= 16'h0000;
            encoder_pulses_per_rev <= `PSS_R_ENC_PPR;
            encoder_type_select    <= 4'h0;
            speed_display_filter   <= `PSS_R_DISP_FILT;
            speed_integral_time    <= 16'h0000;
            correction_freq_limit  <= `PSS_R_CORR_LIM;
            encoder_fault_action   <= 2'h0;
            encoder_fault_time     <= `PSS_R_FLT_TIME;
            slip_comp_limit        <= `PSS_R_SLIP_LIM;
            multi_output_select    <= 32'h00000000;
            display_select         <= 8'h00;
            general_start_freq     <= 16'h0000;
        end else if (wr) begin
            case (PADDR)
                `PSS_A_CURVE:       curve <= PWDATA[2:0];
                `PSS_A_AUX_START_F: aux_start_freq <= wd;
                `PSS_A_AUX_STOP_F:  aux_stop_freq <= wd;
                `PSS_A_AUX_START_D: aux_start_delay <= wd;
                `PSS_A_AUX_STOP_D:  aux_stop_delay <= wd;
                `PSS_A_SLEEP_F:     sleep_freq <= wd;
                `PSS_A_WAKE_F:      wake_freq <= wd;
                `PSS_A_SLEEP_T:     sleep_time <= wd;
                `PSS_A_ENC_PPR:     encoder_pulses_per_rev <= ppr_in;
                `PSS_A_ENC_TYPE:    encoder_type_select <= PWDATA[3:0];
                `PSS_A_DISP_FILT:   speed_display_filter <= wd;
                `PSS_A_ITIME:       speed_integral_time <= wd;
                `PSS_A_CORR_LIM:    correction_freq_limit <= wd;
                `PSS_A_FLT_ACT:     encoder_fault_action <= PWDATA[1:0];
                `PSS_A_FLT_TIME:    encoder_fault_time <= wd;
                `PSS_A_SLIP_LIM:    slip_comp_limit <= wd;
                `PSS_A_MFO_SEL:     multi_output_select <= PWDATA;
                `PSS_A_DISP_SEL:    display_select <= PWDATA[7:0];
                `PSS_A_GEN_START_F: general_start_freq <= wd;
                default:            curve <= curve;
            endcase
        end
    end

    always @* begin
        rd_hit  = 1'b1;
        rd_data = 32'h00000000;
        case (PADDR)
            `PSS_A_CURVE:       rd_data[2:0] = curve;
            `PSS_A_AUX_START_F: rd_data[15:0] = aux_start_freq;
            `PSS_A_AUX_STOP_F:  rd_data[15:0] = aux_stop_freq;
            `PSS_A_AUX_START_D: rd_data[15:0] = aux_start_delay;
            `PSS_A_AUX_STOP_D:  rd_data[15:0] = aux_stop_delay;
            `PSS_A_SLEEP_F:     rd_data[15:0] = sleep_freq;
            `PSS_A_WAKE_F:      rd_data[15:0] = wake_freq;
            `PSS_A_SLEEP_T:     rd_data[15:0] = sleep_time;
            `PSS_A_ENC_PPR:     rd_data[15:0] = encoder_pulses_per_rev;
            `PSS_A_ENC_TYPE:    rd_data[3:0] = encoder_type_select;
            `PSS_A_DISP_FILT:   rd_data[15:0] = speed_display_filter;
            `PSS_A_ITIME:       rd_data[15:0] = speed_integral_time;
            `PSS_A_CORR_LIM:    rd_data[15:0] = correction_freq_limit;
            `PSS_A_FLT_ACT:     rd_data[1:0] = encoder_fault_action;
            `PSS_A_FLT_TIME:    rd_data[15:0] = encoder_fault_time;
            `PSS_A_SLIP_LIM:    rd_data[15:0] = slip_comp_limit;
            `PSS_A_MFO_SEL:     rd_data = multi_output_select;
            `PSS_A_DISP_SEL:    rd_data[7:0] = display_select;
            `PSS_A_GEN_START_F: rd_data[15:0] = general_start_freq;
            `PSS_A_STATUS:      rd_data[4:0] = {fault, sleeping, 1'b0, n_on};
            `PSS_A_SPEED:       rd_data[15:0] = SPEED_DISP;
            `PSS_A_POS:         rd_data = enc_pos;
            default:            rd_hit = 1'b0;
        endcase
    end

    // Read data captured in setup so the access phase ends at once
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            PRDATA  <= 32'h00000000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= 1'b1;
            if (PSEL && !PENABLE) begin
                PRDATA  <= PWRITE ? 32'h00000000 : rd_data;
                PSLVERR <= ~rd_hit;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output mapping, one slice per multi-function output
    genvar j;
    generate
        for (j = 0; j < 4; j = j + 1) begin : g_mfo
            wire [7:0] code = multi_output_select[8*j+7:8*j];
            wire [7:0] idx  = code - `PSS_MFO_AUX1;
            always @* begin
                mfo_is_aux[j] = (code >= `PSS_MFO_AUX1) && (code <= `PSS_MFO_AUX3);
                next_mfo[j]   = mfo_is_aux[j] & aux_on[idx[1:0]];
            end
        end
    endgenerate

    always @* begin
        n_aux = {2'b00, mfo_is_aux[0]} + {2'b00, mfo_is_aux[1]}
              + {2'b00, mfo_is_aux[2]} + {2'b00, mfo_is_aux[3]};
        if (n_aux > 3'h3) begin
            n_aux = 3'h3;
        end
        slot = {1'b0, head} + {1'b0, n_on};
        if (slot >= n_aux) begin
            slot = slot - n_aux;
        end
    end

    assign staging = RUN && !sleeping && (aux_start_freq != 16'h0000) && (n_aux != 3'h0);

    ////////////////////////////////////////////////////////////////////////
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            aux_on    <= 3'h0;
            head      <= 2'h0;
            n_on      <= 2'h0;
            start_tmr <= 16'h0000;
            stop_tmr  <= 16'h0000;
        end else if (!staging || ({1'b0, n_on} > n_aux)) begin
            aux_on    <= 3'h0;
            head      <= 2'h0;
            n_on      <= 2'h0;
            start_tmr <= 16'h0000;
            stop_tmr  <= 16'h0000;
        end else begin
            if ((FREQ_CMD >= aux_start_freq) && ({1'b0, n_on} < n_aux)) begin
                if (start_tmr >= aux_start_delay) begin
                    aux_on[slot[1:0]] <= 1'b1;
                    n_on              <= n_on + 2'h1;
                    start_tmr         <= 16'h0000;
                end else if (tick_100ms) begin
                    start_tmr <= start_tmr + 16'h0001;
                end
            end else begin
                start_tmr <= 16'h0000;
            end
            if ((FREQ_CMD <= aux_stop_freq) && (n_on != 2'h0)) begin
                if (stop_tmr >= aux_stop_delay) begin
                    aux_on[head] <= 1'b0;
                    head         <= ({1'b0, head} + 3'h1 >= n_aux) ? 2'h0 : head + 2'h1;
                    n_on         <= n_on - 2'h1;
                    stop_tmr     <= 16'h0000;
                end else if (tick_100ms) begin
                    stop_tmr <= stop_tmr + 16'h0001;
                end
            end else begin
                stop_tmr <= 16'h0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake compares strictly above, so equal thresholds cannot chatter
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            sleeping  <= 1'b0;
            sleep_tmr <= 16'h0000;
        end else if (!RUN) begin
            sleeping  <= 1'b0;
            sleep_tmr <= 16'h0000;
        end else if (sleeping) begin
            sleep_tmr <= 16'h0000;
            if (FREQ_CMD > wake_freq) begin
                sleeping <= 1'b0;
            end
        end else if (FREQ_CMD < sleep_freq) begin
            if (sleep_tmr >= sleep_time) begin
                sleeping <= 1'b1;
            end else if (tick_100ms) begin
                sleep_tmr <= sleep_tmr + 16'h0001;
            end
        end else begin
            sleep_tmr <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Type decode and direction
    assign enc_inv = (encoder_type_select == `PSS_ENC_BA) ||
                     (encoder_type_select == `PSS_ENC_PID_REV) ||
                     (encoder_type_select == `PSS_ENC_CMD_REV);
    assign enc_on  = (encoder_type_select == `PSS_ENC_AB) || enc_inv ||
                     (encoder_type_select == `PSS_ENC_PID_FWD) ||
                     (encoder_type_select == `PSS_ENC_CMD_FWD);
    assign enc_step = a_sync[1] ^ a_prev ^ b_sync[1] ^ b_prev;
    assign enc_up   = (a_sync[1] ^ b_prev) ^ enc_inv;

    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            a_sync     <= 2'b00;
            b_sync     <= 2'b00;
            a_prev     <= 1'b0;
            b_prev     <= 1'b0;
            enc_pos    <= 32'h00000000;
            win_cnt    <= 16'h0000;
            win_ms     <= 16'h0000;
            SPEED_DISP <= 16'h0000;
        end else begin
            a_sync  <= {a_sync[0], ENC_A};
            b_sync  <= {b_sync[0], ENC_B};
            a_prev  <= a_sync[1];
            b_prev  <= b_sync[1];
            if (enc_on && enc_step) begin
                enc_pos <= enc_up ? enc_pos + 32'h00000001 : enc_pos - 32'h00000001;
            end
            if (tick_ms) begin
                if (win_ms + 16'h0001 >= speed_display_filter) begin
                    win_ms  <= 16'h0000;
                    win_cnt <= 16'h0000;
                    if (display_select == `PSS_DISP_SPEED) begin
                        SPEED_DISP <= win_cnt;
                    end
                end else begin
                    win_ms <= win_ms + 16'h0001;
                end
            end else if (enc_on && enc_step) begin
                win_cnt <= enc_up ? win_cnt + 16'h0001 : win_cnt - 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slip or stall error accumulates
    assign fb_err = RUN && enc_on && (FB_SLIP_ERR || FB_STALL_ERR);

    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            fault     <= 1'b0;
            fault_tmr <= 16'h0000;
        end else begin
            if (fb_err) begin
                if (fault_tmr >= encoder_fault_time) begin
                    fault <= 1'b1;
                end else if (tick_10ms) begin
                    fault_tmr <= fault_tmr + 16'h0001;
                end
            end else begin
                fault_tmr <= 16'h0000;
            end
            // Clear loses to a new detection in the same cycle
            if (fault_clr && !(fb_err && fault_tmr >= encoder_fault_time)) begin
                fault <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    function [15:0] sat;
        input [15:0] v;
        input [15:0] l;
        reg signed [16:0] sv;
        reg signed [16:0] sl;
        reg signed [16:0] nl;
        begin
            sv = {v[15], v};
            sl = {1'b0, l};
            nl = -sl;
            if (sv > sl) begin
                sat = l;
            end else if (sv < nl) begin
                sat = nl[15:0];
            end else begin
                sat = v;
            end
        end
    endfunction

    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            MFO_OUT      <= 4'h0;
            CURVE_SHAPE  <= 2'h0;
            CURVE_SET2   <= 1'b0;
            OUT_ENABLE   <= 1'b0;
            WAKE_RAMP    <= 1'b0;
            START_FREQ   <= 16'h0000;
            PID_ENABLE   <= 1'b0;
            ENC_ENABLE   <= 1'b0;
            ENC_PID_FB   <= 1'b0;
            ENC_FREQ_CMD <= 1'b0;
            ENC_PPR      <= `PSS_R_ENC_PPR;
            INTEG_EN     <= 1'b0;
            CORR_OUT     <= 16'h0000;
            SLIP_OUT     <= 16'h0000;
            FAULT_WARN   <= 1'b0;
            STOP_RAMP    <= 1'b0;
            STOP_COAST   <= 1'b0;
        end else begin
            MFO_OUT      <= next_mfo;
            // Curve shape; code 3 falls back to user
            CURVE_SHAPE  <= (curve[1:0] == 2'h3) ? 2'h0 : curve[1:0];
            CURVE_SET2   <= (curve[1:0] == 2'h0) | (curve[1:0] == 2'h3) ? curve[2] : 1'b0;
            OUT_ENABLE   <= RUN && !sleeping && !(fault && encoder_fault_action == 2'h2);
            WAKE_RAMP    <= sleeping && (FREQ_CMD > wake_freq) && RUN;
            START_FREQ   <= general_start_freq;
            PID_ENABLE   <= RUN;
            ENC_ENABLE   <= enc_on;
            ENC_PID_FB   <= (encoder_type_select == `PSS_ENC_PID_REV) ||
                            (encoder_type_select == `PSS_ENC_PID_FWD);
            ENC_FREQ_CMD <= (encoder_type_select == `PSS_ENC_CMD_REV) ||
                            (encoder_type_select == `PSS_ENC_CMD_FWD);
            ENC_PPR      <= encoder_pulses_per_rev;
            INTEG_EN     <= (speed_integral_time != 16'h0000);
            CORR_OUT     <= sat(SPEED_CORR, correction_freq_limit);
            SLIP_OUT     <= sat(SLIP_COMP, slip_comp_limit);
            FAULT_WARN   <= fault;
            STOP_RAMP    <= fault && (encoder_fault_action == 2'h1);
            STOP_COAST   <= fault && (encoder_fault_action == 2'h2);
        end
    end
endmodule
`default_nettype wire

// ---- test/pss_asserts.sv ----
`default_nettype none
module pss_asserts (
    input wire logic        CLK,
    input wire logic        RESETN,
    input wire logic        RUN,
    input wire logic [1:0]  CURVE_SHAPE,
    input wire logic        OUT_ENABLE,
    input wire logic        WAKE_RAMP,
    input wire logic        PID_ENABLE,
    input wire logic        ENC_ENABLE,
    input wire logic        ENC_PID_FB,
    input wire logic        ENC_FREQ_CMD,
    input wire logic [15:0] ENC_PPR,
    input wire logic        FAULT_WARN,
    input wire logic        STOP_RAMP,
    input wire logic        STOP_COAST
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    a_curve_code: assert property (CURVE_SHAPE != 2'h3) else $error("curve code");
    a_route_one: assert property ((ENC_PID_FB || ENC_FREQ_CMD) |-> ENC_ENABLE
        && !(ENC_PID_FB && ENC_FREQ_CMD)) else $error("encoder route");
    a_ppr_range: assert property (ENC_PPR >= 16'h0001 && ENC_PPR <= 16'h1388)
        else $error("ppr range");
    a_coast_off: assert property (STOP_COAST |-> !OUT_ENABLE && FAULT_WARN)
        else $error("coast");
    a_ramp_warn: assert property (STOP_RAMP |-> FAULT_WARN && !STOP_COAST)
        else $error("ramp");
    a_wake_pulse: assert property (WAKE_RAMP |-> PID_ENABLE ##1 !WAKE_RAMP)
        else $error("wake pulse");
    // Sleep must never gate the command loop
    a_pid_asleep: assert property ($past(RUN) |-> PID_ENABLE) else $error("pid off");
    a_out_run: assert property (OUT_ENABLE |-> $past(RUN)) else $error("out no run");
    c_wake: cover property (WAKE_RAMP);
    c_coast: cover property (STOP_COAST);
    c_pid_fb: cover property (ENC_PID_FB);
endmodule
bind pss_top pss_asserts pss_asserts_i (.*);
`default_nettype wire

// ---- test/pss_enc_model.sv ----
`default_nettype none
module pss_enc_model (
    input wire logic clk,
    input wire logic en,
    input wire logic fwd,
    output logic     a,
    output logic     b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] cnt = '0;
    logic [1:0] ph = '0;
    // Slow steps keep every edge well apart from the pin synchroniser
    always @(posedge clk) begin
        cnt <= cnt + 6'h01;
        if (en && cnt == 6'h3F) ph <= fwd ? ph + 2'h1 : ph - 2'h1;
    end
    assign a = ph[1] ^ ph[0];
    assign b = ph[1];
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, RUN = 0, en = 0, err;
    logic FB_SLIP_ERR = 0, FB_STALL_ERR = 0;
    logic [7:0] PADDR = '0;
    logic [31:0] PWDATA = '0, rdat;
    logic [15:0] FREQ_CMD = '0, SPEED_CORR = '0, SLIP_COMP = '0, v;
    logic [7:0] ra [6] = '{8'h08, 8'h20, 8'h28, 8'h30, 8'h38, 8'h3C};
    logic [15:0] rv [6] = '{16'h01F4, 16'h0400, 16'h001E, 16'h07D0, 16'h000A, 16'h005A};
    logic [3:0] tc [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h8, 4'h9};
    wire [31:0] PRDATA;
    wire [15:0] START_FREQ, ENC_PPR, CORR_OUT, SLIP_OUT, SPEED_DISP;
    wire [3:0] MFO_OUT;
    wire [1:0] CURVE_SHAPE;
    wire PREADY, PSLVERR, CURVE_SET2, OUT_ENABLE, WAKE_RAMP, PID_ENABLE, ENC_ENABLE, ENC_A;
    wire ENC_PID_FB, ENC_FREQ_CMD, INTEG_EN, FAULT_WARN, STOP_RAMP, STOP_COAST, ENC_B;
    int num_errors = 0, n_tests = 0, seed = 42432, i;
    pss_top #(.CYC_PER_MS(10)) pss_top_i (.*);
    pss_enc_model pss_enc_model_i (.clk(CLK), .en(en), .fwd(1'b1), .a(ENC_A), .b(ENC_B));
    always #5 CLK = ~CLK;
    task automatic chk(input logic [32:0] g, e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK) {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
        @(posedge CLK) PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rdat = PRDATA;
        err = PSLVERR;
        {PSEL, PENABLE} <= 2'b00;
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    function automatic logic [15:0] clp(input logic [15:0] x, l);
        return $signed(x) > $signed(l) ? l : ($signed(x) < -$signed(l) ? -l : x);
    endfunction
    task automatic final_report;
        if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge CLK);
        RESETN <= 1'b1;
        tk(2);
        foreach (ra[j]) begin
            apb(0, ra[j], 0);
            chk(rdat, rv[j]);
        end
        apb(0, 8'h80, 0);
        chk({err, rdat}, 33'h100000000);
        for (i = 0; i < 3; i++) begin
            apb(1, 8'h00, 32'(i) | 32'h4);
            apb(1, 8'h2C, i);
            tk(2);
            chk({CURVE_SHAPE, CURVE_SET2, INTEG_EN}, {i[1:0], i == 0, i != 0});
        end
        foreach (tc[j]) begin
            apb(1, 8'h24, tc[j]);
            tk(2);
            chk({ENC_ENABLE, ENC_PID_FB, ENC_FREQ_CMD},
                {tc[j] != 0, tc[j][3:1] == 2, tc[j][3:1] == 4});
        end
        apb(1, 8'h20, 0);
        apb(0, 8'h20, 0);
        chk(rdat, 1);
        for (i = 0; i < 200; i++) begin
            v = (i < 3) ? 16'h07CF + i : $random(seed) % 4096;
            @(posedge CLK) {SPEED_CORR, SLIP_COMP} <= {v, ~v};
            tk(1);
            chk({CORR_OUT, SLIP_OUT}, {clp(v, 16'h07D0), clp(~v, 16'h005A)});
        end
        apb(1, 8'h40, 32'h00001C1B);
        apb(1, 8'h10, 3);
        @(posedge CLK) {RUN, FREQ_CMD} <= {1'b1, 16'h0BB8};
        tk(50);
        chk(MFO_OUT, 0);
        apb(1, 8'h04, 16'h03E8);
        wait (MFO_OUT === 4'h3);
        @(posedge CLK) FREQ_CMD <= 16'h0064;
        tk(1500);
        chk(MFO_OUT, 4'h3);
        wait (MFO_OUT !== 4'h3);
        #1 chk(MFO_OUT, 4'h2);
        apb(1, 8'h00, 0);
        apb(1, 8'h18, 16'h07D0);
        apb(1, 8'h1C, 3);
        apb(1, 8'h48, 16'h0123);
        apb(1, 8'h14, 16'h03E8);
        @(posedge CLK) FREQ_CMD <= 16'h01F4;
        tk(1500);
        @(posedge CLK) FREQ_CMD <= 16'h05DC;
        @(posedge CLK) FREQ_CMD <= 16'h01F4;
        tk(1500);
        chk(OUT_ENABLE, 1);
        wait (OUT_ENABLE === 1'b0);
        #1 chk(PID_ENABLE, 1);
        @(posedge CLK) FREQ_CMD <= 16'h09C4;
        wait (WAKE_RAMP === 1'b1);
        tk(2);
        chk({START_FREQ, OUT_ENABLE}, {16'h0123, 1'b1});
        apb(1, 8'h24, 1);
        for (i = 0; i < 3; i++) begin
            apb(1, 8'h34, i);
            @(posedge CLK) {FB_SLIP_ERR, FB_STALL_ERR} <= {i[0], !i[0]};
            wait (FAULT_WARN === 1'b1);
            tk(1);
            chk({STOP_RAMP, STOP_COAST, OUT_ENABLE}, {i == 1, i == 2, i != 2});
            @(posedge CLK) {FB_SLIP_ERR, FB_STALL_ERR} <= 2'b00;
            apb(1, 8'h4C, 32'h10);
            tk(2);
            chk(FAULT_WARN, 0);
        end
        apb(1, 8'h44, 8'h58);
        for (i = 0; i < 2; i++) begin
            apb(1, 8'h24, i + 1);
            @(posedge CLK) en <= 1'b1;
            tk(700);
            chk($signed(SPEED_DISP) > 0, i == 0);
        end
        final_report;
    end
    initial begin
        #400000;
        num_errors++;
        final_report;
    end
endmodule
`default_nettype wire
